// ==== shared/pwr_mode_pkg.sv ====
// shared constants, states and carriers for the power mode controller
package pwr_mode_pkg;

  // clock rate and documented times
  localparam int CLK_MHZ        = 100;
  localparam int FUSE_READ_US   = 50;
  localparam int FUSE_READ_CYC  = FUSE_READ_US * CLK_MHZ;
  localparam int POLL_ACTIVE_US = 10;
  localparam int POLL_ACTIVE_CYC = POLL_ACTIVE_US * CLK_MHZ;
  localparam int TIMER_TICK_US  = 1;
  localparam int TIMER_TICK_CYC = TIMER_TICK_US * CLK_MHZ;

  // channel layout: ground inputs first, programmable inputs on top
  localparam int NUM_SG     = 14;
  localparam int NUM_SP     = 8;
  localparam int NUM_SW     = NUM_SG + NUM_SP;
  localparam int NUM_THERMAL_LIMIT_FAULT   = 4;
  localparam int TMR_W      = 8;

  // synchronised pin group: bit positions and idle values
  localparam int PIN_POR    = 0;
  localparam int PIN_BUV    = 1;
  localparam int PIN_IOOK   = 2;
  localparam int PIN_CS     = 3;
  localparam int PIN_INT    = 4;
  localparam int PIN_WAKE   = 5;
  localparam int PIN_OV     = 6;
  localparam int PIN_OT     = 7;
  localparam int PIN_TWARN  = 8;
  localparam int PIN_W      = 9;
  localparam logic [PIN_W-1:0] PIN_RST_VAL = 9'h039;

  typedef enum logic [2:0] {
    ST_RESET  = 3'h0,
    ST_UVLO   = 3'h1,
    ST_FUSE   = 3'h3,
    ST_NORMAL = 3'h2,
    ST_LOWPWR = 3'h6,
    ST_POLL   = 3'h7,
    ST_VCHECK = 3'h5,
    ST_SPARE  = 3'h4
  } pwr_state_t;

  typedef struct packed {
    logic [TMR_W-1:0] int_period;
    logic [TMR_W-1:0] poll_period;
  } lp_config_t;

  typedef struct packed {
    logic overvoltage;
    logic overtemperature;
    logic thermal_warning;
    logic spi_error;
    logic hash_error;
  } fault_flags_t;

endpackage : pwr_mode_pkg

// ==== core/level_sync.sv ====
// two flip-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
module level_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             core_clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : level_sync

// ==== core/tick_timer.sv ====
// prescaled periodic timer with one-cycle expiry pulse
`timescale 1ns/1ps
module tick_timer #(
  parameter int TICK_CYC = 100,
  parameter int PW       = 8
) (
  input  wire logic          core_clk,
  input  wire logic          nrst,
  input  wire logic          load,
  input  wire logic          run,
  input  wire logic [PW-1:0] period,
  output logic               expire
);

  localparam int PS_W = $clog2(TICK_CYC + 1);
  localparam logic [PS_W-1:0] PS_LAST = PS_W'(TICK_CYC - 1);

  logic [PS_W-1:0] pre_reg;
  logic [PW-1:0]   cnt_reg;
  logic            tick;
  logic            hit;

  // period of zero never expires
  assign tick = run && (pre_reg == PS_LAST);
  assign hit  = tick && (period != '0) && (cnt_reg == period - PW'(1));

  // prescaler and tick counter restart on load, hold while stopped
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pre_reg <= '0;
      cnt_reg <= '0;
      expire  <= 1'b0;
    end else begin
      pre_reg <= (load || tick) ? '0 : (run ? pre_reg + PS_W'(1) : pre_reg);
      cnt_reg <= (load || hit) ? '0 : (tick ? cnt_reg + PW'(1) : cnt_reg);
      expire  <= hit && !load;
    end
  end

endmodule : tick_timer

// ==== core/switch_monitor_power_mode_fsm.sv ====
// operating state controller: reset, lockout, fuse read, normal, low power, polling
`timescale 1ns/1ps
module switch_monitor_power_mode_fsm #(
  parameter int FUSE_CYC = pwr_mode_pkg::FUSE_READ_CYC,
  parameter int POLL_CYC = pwr_mode_pkg::POLL_ACTIVE_CYC,
  parameter int TICK_CYC = pwr_mode_pkg::TIMER_TICK_CYC
) (
  input  wire logic                                core_clk,
  input  wire logic                                nrst,
  input  wire logic                                por_active,
  input  wire logic                                battery_supply_low,
  input  wire logic                                io_supply_ok,
  input  wire logic                                cs_n_in,
  input  wire logic                                int_n_in,
  input  wire logic                                wake_n_in,
  input  wire logic                                overvoltage_raw,
  input  wire logic                                overtemperature_event,
  input  wire logic                                thermal_warn_raw,
  input  wire logic [pwr_mode_pkg::NUM_THERMAL_LIMIT_FAULT-1:0]   thermal_limit_fault_trip,
  input  wire logic [pwr_mode_pkg::NUM_THERMAL_LIMIT_FAULT-1:0]   thermal_limit_fault_cooled,
  input  wire logic [pwr_mode_pkg::NUM_SW-1:0]     sw_above_thresh,
  input  wire logic                                spi_error,
  input  wire logic                                hash_error,
  input  wire logic                                cmd_enter_lp,
  input  wire pwr_mode_pkg::lp_config_t            lp_config,
  input  wire logic [pwr_mode_pkg::NUM_SW-1:0]     wake_enable,
  input  wire logic [pwr_mode_pkg::NUM_SW-1:0]     comparator_only,
  input  wire logic [pwr_mode_pkg::NUM_SP-1:0]     battery_switch_config,
  input  wire logic                                wake_pin_wake_en,
  input  wire logic                                status_clear,
  input  wire logic                                frame_done,
  output pwr_mode_pkg::pwr_state_t                 state,
  output logic                                     fast_osc_en,
  output logic                                     slow_osc_en,
  output logic                                     fault_detect_en,
  output logic                                     spi_enable,
  output logic                                     spi_word_abort,
  output logic                                     analog_mux_output_enable,
  output logic                                     current_src_en,
  output logic                                     poll_active,
  output logic                                     wake_n_out,
  output logic                                     wake_n_oe,
  output logic                                     int_request,
  output logic                                     wake_report,
  output logic                                     discard_first_frame,
  output logic                                     por_seen,
  output logic                                     uv_seen,
  output pwr_mode_pkg::fault_flags_t               fault_flags,
  output logic                                     thermal_limit_fault,
  output logic                                     wetting_limit_low,
  output logic [pwr_mode_pkg::NUM_SW-1:0]          switch_closed,
  output logic [pwr_mode_pkg::NUM_SW-1:0]          switch_changed
);

  localparam int NSW = pwr_mode_pkg::NUM_SW;
  localparam int NT  = pwr_mode_pkg::NUM_THERMAL_LIMIT_FAULT;
  localparam int FW  = $clog2(FUSE_CYC + 1);
  localparam int PW  = $clog2(POLL_CYC + 1);
  localparam logic [FW-1:0] FUSE_LAST = FW'(FUSE_CYC - 1);
  localparam logic [PW-1:0] POLL_LAST = PW'(POLL_CYC - 1);

  pwr_mode_pkg::pwr_state_t state_next;
  logic [pwr_mode_pkg::PIN_W-1:0] pin_s;
  logic [NSW+2*NT-1:0]            ana_s;
  logic [NSW-1:0] sw_above_s, closed_now, sb_mask, delta, snap_reg, poll_mask_reg;
  logic [NT-1:0]  trip_s, cooled_s;
  logic [FW-1:0]  fuse_cnt_reg;
  logic [PW-1:0]  poll_cnt_reg;
  logic [2:0]     edge_prev_reg;
  logic por_s, buv_s, iook_s, cs_fall, int_fall, wake_fall, pin_wake;
  logic in_lp, any_wake_en, comp_wake, poll_wake, poll_done, fuse_done;
  logic int_expire, poll_expire, lp_entry, cs_cause_reg;
  logic int_req_next, wake_rep_next;
  logic [4:0]     fault_now;

  // asynchronous pins and comparator levels
  level_sync #(.WIDTH(pwr_mode_pkg::PIN_W), .RST_VAL(pwr_mode_pkg::PIN_RST_VAL)) u_pin_sync (
    .core_clk (core_clk),
    .nrst     (nrst),
    .async_in ({thermal_warn_raw, overtemperature_event, overvoltage_raw, wake_n_in,
                int_n_in, cs_n_in, io_supply_ok, battery_supply_low, por_active}),
    .sync_out (pin_s)
  );
  level_sync #(.WIDTH(NSW + 2 * NT), .RST_VAL('0)) u_ana_sync (
    .core_clk (core_clk),
    .nrst     (nrst),
    .async_in ({thermal_limit_fault_cooled, thermal_limit_fault_trip, sw_above_thresh}),
    .sync_out (ana_s)
  );

  assign por_s      = pin_s[pwr_mode_pkg::PIN_POR];
  assign buv_s      = pin_s[pwr_mode_pkg::PIN_BUV];
  assign iook_s     = pin_s[pwr_mode_pkg::PIN_IOOK];
  assign sw_above_s = ana_s[NSW-1:0];
  assign trip_s     = ana_s[NSW+NT-1:NSW];
  assign cooled_s   = ana_s[NSW+2*NT-1:NSW+NT];

  // falling edges of the wake sources, seen only in low power
  assign cs_fall   = edge_prev_reg[0] && !pin_s[pwr_mode_pkg::PIN_CS];
  assign int_fall  = edge_prev_reg[1] && !pin_s[pwr_mode_pkg::PIN_INT];
  assign wake_fall = edge_prev_reg[2] && !pin_s[pwr_mode_pkg::PIN_WAKE] && wake_pin_wake_en;
  assign pin_wake  = cs_fall || int_fall || wake_fall;

  // open/closed sense per channel type
  assign sb_mask    = {battery_switch_config, {pwr_mode_pkg::NUM_SG{1'b0}}};
  assign closed_now = sw_above_s ^ ~sb_mask;
  assign delta      = (closed_now ^ snap_reg) & wake_enable;

  // wake conditions while asleep
  assign in_lp       = (state == pwr_mode_pkg::ST_LOWPWR) || (state == pwr_mode_pkg::ST_POLL);
  assign any_wake_en = |wake_enable;
  assign comp_wake   = in_lp && |(delta & comparator_only);
  assign poll_done   = (state == pwr_mode_pkg::ST_POLL) && !buv_s && (poll_cnt_reg == POLL_LAST);
  assign poll_wake   = poll_done && |(delta & poll_mask_reg);
  assign fuse_done   = (fuse_cnt_reg == FUSE_LAST);
  assign lp_entry    = (state == pwr_mode_pkg::ST_NORMAL) && cmd_enter_lp && !buv_s;

  // interrupt timer runs all through low power
  tick_timer #(.TICK_CYC(TICK_CYC), .PW(pwr_mode_pkg::TMR_W)) u_int_tmr (
    .core_clk (core_clk),
    .nrst     (nrst),
    .load     (lp_entry),
    .run      (in_lp),
    .period   (lp_config.int_period),
    .expire   (int_expire)
  );
  // poll timer stops without wake enables and pauses on low battery
  tick_timer #(.TICK_CYC(TICK_CYC), .PW(pwr_mode_pkg::TMR_W)) u_poll_tmr (
    .core_clk (core_clk),
    .nrst     (nrst),
    .load     (lp_entry),
    .run      ((state == pwr_mode_pkg::ST_LOWPWR) && any_wake_en && !buv_s),
    .period   (lp_config.poll_period),
    .expire   (poll_expire)
  );

  // next state and the one-cycle reports that go with it
  always_comb begin
    state_next    = state;
    int_req_next  = 1'b0;
    wake_rep_next = 1'b0;
    unique case (state)
      pwr_mode_pkg::ST_RESET:
        if (!por_s) state_next = pwr_mode_pkg::ST_UVLO;
      pwr_mode_pkg::ST_UVLO:
        if (!buv_s) state_next = pwr_mode_pkg::ST_FUSE;
      pwr_mode_pkg::ST_FUSE:
        if (buv_s) state_next = pwr_mode_pkg::ST_UVLO;
        else if (fuse_done) state_next = pwr_mode_pkg::ST_NORMAL;
      pwr_mode_pkg::ST_NORMAL:
        if (buv_s) state_next = pwr_mode_pkg::ST_UVLO;
        else if (lp_entry) state_next = pwr_mode_pkg::ST_LOWPWR;
      pwr_mode_pkg::ST_LOWPWR, pwr_mode_pkg::ST_POLL: begin
        if (int_expire) begin
          state_next   = pwr_mode_pkg::ST_VCHECK;
          int_req_next = 1'b1;
        end else if (comp_wake || poll_wake) begin
          state_next    = pwr_mode_pkg::ST_VCHECK;
          wake_rep_next = 1'b1;
        end else if (pin_wake) state_next = pwr_mode_pkg::ST_VCHECK;
        else if (poll_done) state_next = pwr_mode_pkg::ST_LOWPWR;
        else if (poll_expire) state_next = pwr_mode_pkg::ST_POLL;
      end
      pwr_mode_pkg::ST_VCHECK: begin
        // fast clock restarts here; fault detection waits for normal mode
        if (iook_s || int_request || wake_report) begin
          state_next    = pwr_mode_pkg::ST_NORMAL;
          wake_rep_next = !wake_report && !int_request;
        end else state_next = pwr_mode_pkg::ST_LOWPWR;
      end
      default: state_next = pwr_mode_pkg::ST_RESET;
    endcase
    if (por_s) state_next = pwr_mode_pkg::ST_RESET;
  end

  // state, counters, edge history
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state         <= pwr_mode_pkg::ST_RESET;
      fuse_cnt_reg  <= '0;
      poll_cnt_reg  <= '0;
      edge_prev_reg <= 3'h7;
      int_request   <= 1'b0;
      wake_report   <= 1'b0;
    end else begin
      state         <= state_next;
      fuse_cnt_reg  <= (state == pwr_mode_pkg::ST_FUSE) ? fuse_cnt_reg + FW'(1) : '0;
      poll_cnt_reg  <= (state != pwr_mode_pkg::ST_POLL) ? '0
                       : (buv_s ? poll_cnt_reg : poll_cnt_reg + PW'(1));
      // always tracks the pins, so a pin still low at entry gives no false fall
      edge_prev_reg <= {pin_s[pwr_mode_pkg::PIN_WAKE], pin_s[pwr_mode_pkg::PIN_INT],
                        pin_s[pwr_mode_pkg::PIN_CS]};
      int_request   <= int_req_next;
      wake_report   <= wake_rep_next;
    end
  end

  // entry snapshot and poll mask; loaded at low power entry, cleared by power-on reset, mask narrowed after each poll
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      snap_reg      <= '0;
      poll_mask_reg <= '0;
    end else if (por_s) begin
      snap_reg      <= '0;
      poll_mask_reg <= '0;
    end else if (lp_entry) begin
      snap_reg      <= closed_now;
      poll_mask_reg <= ~comparator_only;
    end else if (poll_done) begin
      poll_mask_reg <= poll_mask_reg & ~(~snap_reg & ~closed_now);
    end
  end

  // live fault levels, latched only while detection runs
  assign fault_now = {pin_s[pwr_mode_pkg::PIN_OV], pin_s[pwr_mode_pkg::PIN_OT],
                      pin_s[pwr_mode_pkg::PIN_TWARN], spi_error, hash_error};

  // status: set wins over clear; fault_flags latch only in normal mode
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      por_seen            <= 1'b0;
      uv_seen             <= 1'b0;
      fault_flags         <= '0;
      cs_cause_reg        <= 1'b0;
      discard_first_frame <= 1'b0;
      thermal_limit_fault <= 1'b0;
      switch_closed       <= '0;
      switch_changed      <= '0;
    end else begin
      por_seen <= (state == pwr_mode_pkg::ST_RESET && !por_s)
                  || (por_seen && !status_clear);
      uv_seen  <= (state == pwr_mode_pkg::ST_UVLO) || (uv_seen && !status_clear);
      fault_flags <= (por_s ? '0 : (status_clear ? '0 : fault_flags))
                     | (fault_detect_en ? fault_now : 5'h00);
      cs_cause_reg <= in_lp ? (cs_fall || cs_cause_reg) : 1'b0;
      discard_first_frame <= (state == pwr_mode_pkg::ST_VCHECK && state_next ==
                              pwr_mode_pkg::ST_NORMAL && cs_cause_reg)
                             || (discard_first_frame && !frame_done);
      thermal_limit_fault <= |trip_s || (thermal_limit_fault && !(&cooled_s));
      switch_closed  <= closed_now;
      switch_changed <= in_lp ? delta : '0;
    end
  end

  // mode-dependent enables
  assign slow_osc_en     = (state != pwr_mode_pkg::ST_RESET);
  assign fast_osc_en     = slow_osc_en && !in_lp;
  assign fault_detect_en = (state == pwr_mode_pkg::ST_NORMAL);
  assign spi_enable      = (state == pwr_mode_pkg::ST_NORMAL);
  assign spi_word_abort  = (state == pwr_mode_pkg::ST_NORMAL) && buv_s;
  assign analog_mux_output_enable     = (state == pwr_mode_pkg::ST_NORMAL);
  assign poll_active     = (state == pwr_mode_pkg::ST_POLL) && !buv_s;
  assign current_src_en  = (state == pwr_mode_pkg::ST_NORMAL) || poll_active;
  assign wake_n_out      = 1'b0;
  assign wake_n_oe       = (state == pwr_mode_pkg::ST_NORMAL);
  assign wetting_limit_low = thermal_limit_fault;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_reset_hold: assert property (por_s |=> state == pwr_mode_pkg::ST_RESET)
    else $error("reset state not held during power-on reset");
  a_uv_quiet: assert property (state == pwr_mode_pkg::ST_UVLO |->
      !spi_enable && !analog_mux_output_enable && !current_src_en)
    else $error("lockout left serial, analog or currents active");
  a_osc_on: assert property (state == pwr_mode_pkg::ST_UVLO |->
      slow_osc_en && fast_osc_en)
    else $error("oscillators off in lockout");
  a_fuse_time: assert property (state == pwr_mode_pkg::ST_FUSE
      && fuse_cnt_reg == FUSE_LAST && !buv_s && !por_s |=> state == pwr_mode_pkg::ST_NORMAL)
    else $error("fuse read did not end in normal mode");
  a_wake_low: assert property (state == pwr_mode_pkg::ST_NORMAL |->
      wake_n_oe && !wake_n_out)
    else $error("wake pin not driven low in normal mode");
  a_lp_entry: assert property (state == pwr_mode_pkg::ST_LOWPWR
      && $past(state) == pwr_mode_pkg::ST_NORMAL |-> $past(cmd_enter_lp))
    else $error("low power entered without its command");
  a_no_fault_lp: assert property (in_lp |=> (fault_flags & ~$past(fault_flags)) == '0)
    else $error("fault latched during low power");
  a_int_priority: assert property (in_lp && int_expire && !por_s |=>
      state == pwr_mode_pkg::ST_VCHECK && int_request
      ##1 (state == pwr_mode_pkg::ST_NORMAL || $past(por_s)))
    else $error("interrupt timer wake lost to polling");
  a_vcheck_low: assert property (state == pwr_mode_pkg::ST_VCHECK
      && !iook_s && !int_request && !wake_report && !por_s |=>
      state == pwr_mode_pkg::ST_LOWPWR && !wake_report)
    else $error("pin wake with io supply low did not return to low power");

endmodule : switch_monitor_power_mode_fsm

// ==== sim/host_model.sv ====
// host controller model: select, wake pin, low power command, frame drop
`timescale 1ns/1ps
module host_model (
  input  wire logic core_clk,
  input  wire logic do_lp,
  input  wire logic do_sel,
  input  wire logic do_wake,
  input  wire logic do_frame,
  input  wire logic wake_n_out,
  input  wire logic wake_n_oe,
  input  wire logic discard_first_frame,
  output logic      cmd_enter_lp,
  output logic      cs_n_in,
  output logic      wake_n_in,
  output logic      frame_done
);
  logic [2:0] sel_cnt = 3'h0;
  logic [2:0] wk_cnt  = 3'h0;
  // pins idle high by pull-up, pulled low while a count runs
  assign cs_n_in      = (sel_cnt == 3'h0);
  assign wake_n_in    = !(wake_n_oe && !wake_n_out) && (wk_cnt == 3'h0);
  assign cmd_enter_lp = do_lp;
  assign frame_done   = do_frame && discard_first_frame;
  // low pulses of four cycles on select and wake pins
  always @(posedge core_clk) begin
    sel_cnt <= do_sel ? 3'h4 : sel_cnt - {2'h0, sel_cnt != 3'h0};
    wk_cnt  <= do_wake ? 3'h4 : wk_cnt - {2'h0, wk_cnt != 3'h0};
  end
endmodule : host_model

// ==== sim/tb_top.sv ====
// self-checking bench of the power mode controller
`timescale 1ns/1ps
module tb_top;
  logic core_clk = 0, nrst = 0, por_active = 0, battery_supply_low = 1, io_supply_ok = 1;
  logic cs_n_in, int_n_in = 1, wake_n_in, overvoltage_raw = 0, overtemperature_event = 0;
  logic thermal_warn_raw = 0, spi_error = 0, hash_error = 0, cmd_enter_lp, status_clear = 0;
  logic frame_done, wake_pin_wake_en = 0, do_lp = 0, do_sel = 0, do_wake = 0, do_frame = 0;
  logic [3:0] thermal_limit_fault_trip = 0, thermal_limit_fault_cooled = 4'hF;
  logic [21:0] sw_above_thresh = 0, wake_enable = 0, comparator_only = 0;
  logic [7:0] battery_switch_config = 0;
  pwr_mode_pkg::lp_config_t lp_config = 0;
  pwr_mode_pkg::pwr_state_t state;
  logic fast_osc_en, slow_osc_en, fault_detect_en, spi_enable, spi_word_abort, analog_mux_output_enable;
  logic current_src_en, poll_active, wake_n_out, wake_n_oe, int_request, wake_report;
  logic discard_first_frame, por_seen, uv_seen, thermal_limit_fault, wetting_limit_low;
  pwr_mode_pkg::fault_flags_t fault_flags;
  logic [21:0] switch_closed, switch_changed;
  logic got_int = 0, got_rep = 0, got_poll = 0, got_abort = 0, got_chg = 0;
  int n_fail = 0, samples_checked = 0, n;

  switch_monitor_power_mode_fsm #(.FUSE_CYC(20), .POLL_CYC(8), .TICK_CYC(4)) DUT (.*);
  host_model host (.*);

  always #5 core_clk = ~core_clk;
  // catch one-cycle pulses and short windows
  always @(posedge core_clk) begin
    got_int   |= int_request;
    got_rep   |= wake_report;
    got_poll  |= poll_active;
    got_abort |= spi_word_abort;
    got_chg   |= switch_changed[0];
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(negedge core_clk);
  endtask : cyc

  task automatic req(ref logic r);
    r = 1'b1;
    cyc(1);
    r = 1'b0;
  endtask : req

  task automatic wait_st(input pwr_mode_pkg::pwr_state_t s);
    for (int i = 0; i < 200 && state !== s; i++) cyc(1);
    chk("state", s, state);
  endtask : wait_st

  // program timers, enter low power, clear pulse catchers other than got_abort
  task automatic enter_lp(input logic [15:0] cfg);
    lp_config = cfg;
    req(do_lp);
    cyc(2);
    {got_int, got_rep, got_poll, got_chg} = 4'h0;
    chk("lp state", pwr_mode_pkg::ST_LOWPWR, state);
  endtask : enter_lp

  // closed reading per channel from comparator and battery wiring
  function automatic logic [21:0] exp_closed(input logic [21:0] a, input logic [7:0] b);
    exp_closed = ~a;
    for (int i = 0; i < 8; i++) if (b[i]) exp_closed[14+i] = a[14+i];
  endfunction : exp_closed

  initial begin
    #100us;
    n_fail++;
    test_done();
  end

  initial begin
    n = $urandom(6);
    cyc(6);
    chk("reset state", pwr_mode_pkg::ST_RESET, state);
    nrst = 1;
    wait_st(pwr_mode_pkg::ST_UVLO);
    chk("por seen", 1, por_seen);
    chk("lockout outputs", 0, {spi_enable, analog_mux_output_enable, current_src_en});
    chk("oscillators", 3, {slow_osc_en, fast_osc_en});
    battery_supply_low = 0;
    wait_st(pwr_mode_pkg::ST_FUSE);
    for (n = 0; n < 100 && state === pwr_mode_pkg::ST_FUSE; n++) cyc(1);
    chk("fuse cycles", 20, n);
    chk("normal", pwr_mode_pkg::ST_NORMAL, state);
    chk("wake pin", 2, {wake_n_oe, wake_n_out});
    chk("normal enables", 7, {spi_enable, analog_mux_output_enable, current_src_en});
    {overvoltage_raw, overtemperature_event, thermal_warn_raw, spi_error, hash_error} = 5'h1F;
    cyc(5);
    chk("ov flag", 1, {fault_detect_en, fault_flags.overvoltage} == 2'h3);
    chk("all faults", 5'h1F, fault_flags);
    {overvoltage_raw, overtemperature_event, thermal_warn_raw, spi_error, hash_error} = 5'h00;
    cyc(3);
    req(status_clear);
    for (int k = 0; k < 8; k++) begin
      sw_above_thresh = 22'($urandom);
      battery_switch_config = 8'($urandom);
      cyc(5);
      chk("closed", exp_closed(sw_above_thresh, battery_switch_config), switch_closed);
    end
    thermal_limit_fault_trip = 4'h1 << ($urandom % 4);
    thermal_limit_fault_cooled = 0;
    cyc(5);
    chk("thermal_limit_fault", 3, {thermal_limit_fault, wetting_limit_low});
    {thermal_limit_fault_trip, thermal_limit_fault_cooled} = 8'h0F;
    cyc(5);
    chk("thermal_limit_fault off", 0, {thermal_limit_fault, wetting_limit_low});
    req(do_sel);
    cyc(8);
    chk("select stays normal", pwr_mode_pkg::ST_NORMAL, state);
    enter_lp(16'h0002);
    chk("lp clocks", 0, {fast_osc_en, fault_detect_en, wake_n_oe});
    overvoltage_raw = 1;
    sw_above_thresh = ~sw_above_thresh;
    cyc(40);
    chk("no poll", 0, {got_poll, got_rep});
    overvoltage_raw = 0;
    io_supply_ok = 0;
    req(do_sel);
    cyc(8);
    chk("io low stays", pwr_mode_pkg::ST_LOWPWR, {got_rep, state});
    io_supply_ok = 1;
    req(do_sel);
    wait_st(pwr_mode_pkg::ST_NORMAL);
    cyc(1);
    chk("select wake", 3, {got_rep, discard_first_frame});
    chk("lp fault", 0, fault_flags);
    req(do_frame);
    cyc(2);
    chk("frame drop", 0, discard_first_frame);
    wake_enable = '1;
    sw_above_thresh = 0;
    enter_lp(16'h0303);
    wait_st(pwr_mode_pkg::ST_NORMAL);
    chk("int wins", 2, {got_int, got_poll});
    enter_lp(16'h0002);
    battery_supply_low = 1;
    cyc(40);
    chk("paused", 0, state == pwr_mode_pkg::ST_NORMAL || state == pwr_mode_pkg::ST_UVLO);
    battery_supply_low = 0;
    cyc(60);
    chk("poll quiet", 2, {got_poll, got_rep});
    sw_above_thresh[0] = 1;
    wait_st(pwr_mode_pkg::ST_NORMAL);
    chk("poll change", 3, {got_rep, got_chg});
    comparator_only[1] = 1;
    enter_lp(16'h0000);
    sw_above_thresh[1] = 1;
    cyc(12);
    chk("comparator wake", 1, got_rep && state == pwr_mode_pkg::ST_NORMAL);
    wake_pin_wake_en = 1;
    enter_lp(16'h0000);
    req(do_wake);
    wait_st(pwr_mode_pkg::ST_NORMAL);
    cyc(1);
    chk("wake pin wake", 1, got_rep);
    enter_lp(16'h0000);
    int_n_in = 0;
    wait_st(pwr_mode_pkg::ST_NORMAL);
    cyc(1);
    chk("int pin wake", 1, got_rep);
    int_n_in = 1;
    battery_supply_low = 1;
    wait_st(pwr_mode_pkg::ST_UVLO);
    chk("abort", 2, {got_abort, spi_enable});
    battery_supply_low = 0;
    wait_st(pwr_mode_pkg::ST_NORMAL);
    chk("uv seen", 1, uv_seen);
    por_active = 1;
    wait_st(pwr_mode_pkg::ST_RESET);
    por_active = 0;
    wait_st(pwr_mode_pkg::ST_UVLO);
    chk("por again", 1, por_seen);
    test_done();
  end
endmodule : tb_top
